/* File: sdfm_defines.svh */
// Contract
// - report code 104 when the phase current sensor is flagged failed.
// - report code 105 when the encoder signal is missing or unstable.
// - report code 106 when parameter memory read data is erroneous.
// - report code 107 when hall phase and encoder phase differ too much.
// - mask bit 2 set suppresses code 107.
// - report code 108 when written and read-back register values differ.
// - report code 109 when two successive current samples differ by 50 percent.
// - mask bit 3 set suppresses code 109.
// - report code 111 when winding learning sees current move the wrong way.
// - report code 113 when encoder learning finds no index pulse.
// - report code 114 when index position exceeds encoder resolution.
// - report code 115 when hall bits read all zeros or all ones in learning.
// - report code 117 when temperature is strictly above overheat threshold.
// - report code 118 when reduced-wire encoder power-on hall code is invalid.
// - report code 119 when recognized encoder type differs from configured type.
`ifndef SDFM_DEFINES_SVH
`define SDFM_DEFINES_SVH
`define SDFM_CODE_W 8
`define SDFM_CODE_NONE 8'h00
`define SDFM_CODE_CUR_SENSOR 8'h68
`define SDFM_CODE_ENCODER 8'h69
`define SDFM_CODE_NVM 8'h6A
`define SDFM_CODE_PHASE 8'h6B
`define SDFM_CODE_REGPATH 8'h6C
`define SDFM_CODE_JUMP 8'h6D
`define SDFM_CODE_WINDING 8'h6F
`define SDFM_CODE_NO_INDEX 8'h71
`define SDFM_CODE_INDEX_POS 8'h72
`define SDFM_CODE_HALL 8'h73
`define SDFM_CODE_OVERHEAT 8'h75
`define SDFM_CODE_PWRON_HALL 8'h76
`define SDFM_CODE_ENC_TYPE 8'h77
`define SDFM_MASK_PHASE_BIT 2
`define SDFM_MASK_JUMP_BIT 3
`define SDFM_MASK_W 16
`define SDFM_CUR_W 16
`define SDFM_TEMP_W 16
`define SDFM_POS_W 24
`define SDFM_TYPE_W 4
`define SDFM_NUM_SRC 13
`endif

/* File: sdfm_pkg.sv */
package sdfm_pkg;
  typedef enum logic [1:0] {SDFM_IDLE, SDFM_LATCHED} sdfm_state_type;
endpackage

/* File: sdfm_jump_det.sv */
`timescale 1ns/1ps
`default_nettype none
`include "sdfm_defines.svh"
// flags a 50 percent change between two successive current samples
module sdfm_jump_det (
  input wire logic i_mclk,
  input wire logic i_rst_n,
  input wire logic i_valid,
  input wire logic signed [`SDFM_CUR_W-1:0] i_sample,
  output logic o_jump
);
  logic signed [`SDFM_CUR_W-1:0] prev_q;
  logic have_q;
  logic signed [`SDFM_CUR_W+1:0] diff;
  logic [`SDFM_CUR_W+1:0] diff_abs;
  logic [`SDFM_CUR_W+1:0] prev_abs;
  logic [`SDFM_CUR_W+1:0] half_prev;
  assign diff = (`SDFM_CUR_W+2)'(i_sample) - (`SDFM_CUR_W+2)'(prev_q);
  assign diff_abs = diff[`SDFM_CUR_W+1] ? (`SDFM_CUR_W+2)'(-diff) : diff;
  assign prev_abs = prev_q[`SDFM_CUR_W-1] ? (`SDFM_CUR_W+2)'(-(`SDFM_CUR_W+2)'(prev_q))
                                          : (`SDFM_CUR_W+2)'(prev_q);
  assign half_prev = prev_abs >> 1;
  // difference at least half of the earlier sample, nonzero reference
  assign o_jump = i_valid && have_q && (prev_abs != '0) && (diff_abs >= half_prev);
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      prev_q <= '0;
      have_q <= 1'b0;
    end else if (i_valid) begin
      prev_q <= i_sample;
      have_q <= 1'b1;
    end
  end
endmodule
`default_nettype wire

/* File: sdfm_top.sv */
`timescale 1ns/1ps
`default_nettype none
`include "sdfm_defines.svh"
module sdfm_top (
  input wire logic i_mclk,
  input wire logic i_rst_n,
  input wire logic i_cur_sensor_fail,
  input wire logic i_enc_signal_bad,
  input wire logic i_nvm_read_err,
  input wire logic i_phase_diff_big,
  input wire logic i_reg_wr_valid,
  input wire logic [31:0] i_reg_wr_value,
  input wire logic [31:0] i_reg_rd_value,
  input wire logic i_cur_valid,
  input wire logic [`SDFM_CUR_W-1:0] i_cur_sample,
  input wire logic i_wind_learn,
  input wire logic i_wind_wrong_dir,
  input wire logic i_enc_learn_done,
  input wire logic i_index_seen,
  input wire logic [`SDFM_POS_W-1:0] i_index_pos,
  input wire logic [`SDFM_POS_W-1:0] i_enc_resolution,
  input wire logic i_enc_learn,
  input wire logic [2:0] i_hall,
  input wire logic [`SDFM_TEMP_W-1:0] i_drive_temperature_reading,
  input wire logic [`SDFM_TEMP_W-1:0] i_overheat_threshold,
  input wire logic i_pwron_check,
  input wire logic i_reduced_wire_enc,
  input wire logic [`SDFM_TYPE_W-1:0] i_detected_encoder_type,
  input wire logic [`SDFM_TYPE_W-1:0] i_configured_encoder_type,
  input wire logic [`SDFM_MASK_W-1:0] i_fault_mask_parameter,
  input wire logic i_fault_clear,
  output logic o_fault_active,
  output logic [`SDFM_CODE_W-1:0] o_fault_code,
  output logic [`SDFM_NUM_SRC-1:0] o_fault_flags
);
  // pin-level inputs pass two flip-flops
  logic [2:0] hall_s1_q;
  logic [2:0] hall_q;
  logic [2:0] pin_s1_q;
  logic [2:0] pin_q;
  wire [2:0] pin_raw = {i_cur_sensor_fail, i_enc_signal_bad, i_phase_diff_big};
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      hall_s1_q <= 3'h0;
      hall_q <= 3'h0;
      pin_s1_q <= 3'h0;
      pin_q <= 3'h0;
    end else begin
      hall_s1_q <= i_hall;
      hall_q <= hall_s1_q;
      pin_s1_q <= pin_raw;
      pin_q <= pin_s1_q;
    end
  end

  wire jump_raw;
  sdfm_jump_det u_jump (
    .i_mclk(i_mclk),
    .i_rst_n(i_rst_n),
    .i_valid(i_cur_valid),
    .i_sample(i_cur_sample),
    .o_jump(jump_raw)
  );

  // hall code trusted only once the sync chain holds real pin samples
  logic [1:0] hall_fill_q;
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      hall_fill_q <= 2'h0;
    end else begin
      hall_fill_q <= {hall_fill_q[0], 1'b1};
    end
  end
  wire hall_bad = hall_fill_q[1] && ((hall_q == 3'h0) || (hall_q == 3'h7));
  wire mask_phase = i_fault_mask_parameter[`SDFM_MASK_PHASE_BIT];
  wire mask_jump = i_fault_mask_parameter[`SDFM_MASK_JUMP_BIT];

  // detection terms in priority order, lowest index wins
  wire [`SDFM_NUM_SRC-1:0] det;
  assign det[0] = pin_q[2];
  assign det[1] = pin_q[1];
  assign det[2] = i_nvm_read_err;
  assign det[3] = pin_q[0] && !mask_phase;
  assign det[4] = i_reg_wr_valid && (i_reg_wr_value != i_reg_rd_value);
  assign det[5] = jump_raw && !mask_jump;
  assign det[6] = i_wind_learn && i_wind_wrong_dir;
  assign det[7] = i_enc_learn_done && !i_index_seen;
  assign det[8] = i_enc_learn_done && i_index_seen
                  && (i_index_pos > i_enc_resolution);
  assign det[9] = i_enc_learn && hall_bad;
  assign det[10] = i_drive_temperature_reading > i_overheat_threshold;
  assign det[11] = i_pwron_check && i_reduced_wire_enc && hall_bad;
  assign det[12] = i_detected_encoder_type != i_configured_encoder_type;

  localparam logic [`SDFM_CODE_W-1:0] CODES [`SDFM_NUM_SRC] = '{
    `SDFM_CODE_CUR_SENSOR, `SDFM_CODE_ENCODER, `SDFM_CODE_NVM, `SDFM_CODE_PHASE,
    `SDFM_CODE_REGPATH, `SDFM_CODE_JUMP, `SDFM_CODE_WINDING, `SDFM_CODE_NO_INDEX,
    `SDFM_CODE_INDEX_POS, `SDFM_CODE_HALL, `SDFM_CODE_OVERHEAT,
    `SDFM_CODE_PWRON_HALL, `SDFM_CODE_ENC_TYPE};

  // priority encoder
  logic [`SDFM_CODE_W-1:0] sel_code;
  always_comb begin
    sel_code = `SDFM_CODE_NONE;
    for (int k = `SDFM_NUM_SRC - 1; k >= 0; k--) begin
      if (det[k]) begin
        sel_code = CODES[k];
      end
    end
  end
  wire any_det = |det;

  sdfm_pkg::sdfm_state_type state_q;
  logic [`SDFM_CODE_W-1:0] code_q;
  logic [`SDFM_NUM_SRC-1:0] flags_q;

  // sticky per-source flags, set wins over clear
  genvar g;
  generate
    for (g = 0; g < `SDFM_NUM_SRC; g++) begin : g_flag
      always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
          flags_q[g] <= 1'b0;
        end else if (det[g]) begin
          flags_q[g] <= 1'b1;
        end else if (i_fault_clear) begin
          flags_q[g] <= 1'b0;
        end
      end
    end
  endgenerate

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_q <= sdfm_pkg::SDFM_IDLE;
      code_q <= `SDFM_CODE_NONE;
    end else begin
      case (state_q)
        sdfm_pkg::SDFM_IDLE: begin
          if (any_det) begin
            state_q <= sdfm_pkg::SDFM_LATCHED;
            code_q <= sel_code;
          end
        end
        sdfm_pkg::SDFM_LATCHED: begin
          // a fault present during clear re-latches at once
          if (i_fault_clear) begin
            if (any_det) begin
              code_q <= sel_code;
            end else begin
              state_q <= sdfm_pkg::SDFM_IDLE;
              code_q <= `SDFM_CODE_NONE;
            end
          end
        end
        default: begin
          state_q <= sdfm_pkg::SDFM_IDLE;
          code_q <= `SDFM_CODE_NONE;
        end
      endcase
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_fault_active <= 1'b0;
      o_fault_code <= `SDFM_CODE_NONE;
      o_fault_flags <= '0;
    end else begin
      o_fault_active <= (state_q == sdfm_pkg::SDFM_LATCHED);
      o_fault_code <= code_q;
      o_fault_flags <= flags_q;
    end
  end

  sequence s_detect_phase;
    pin_q[0] && !mask_phase && state_q == sdfm_pkg::SDFM_IDLE && !(|det[2:0]);
  endsequence

  sequence s_detect_jump;
    jump_raw && !mask_jump && state_q == sdfm_pkg::SDFM_IDLE && !(|det[4:0]);
  endsequence

  a_latch_holds_code: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    state_q == sdfm_pkg::SDFM_LATCHED && !i_fault_clear |=> $stable(code_q))
    else $error("latched code changed without clear");
  a_phase_code: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    s_detect_phase |=> code_q == `SDFM_CODE_PHASE ##1 o_fault_code == `SDFM_CODE_PHASE)
    else $error("phase fault not reported as 107");
  a_phase_masked: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    mask_phase && pin_q[0] && !flags_q[3] |=> !flags_q[3])
    else $error("masked phase fault detected");
  a_jump_masked: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    mask_jump && jump_raw && !flags_q[5] |=> !flags_q[5])
    else $error("masked jump fault detected");
  a_overheat_flag: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    i_drive_temperature_reading > i_overheat_threshold |-> ##2 o_fault_flags[10])
    else $error("overheat flag not raised");
  a_sensor_first: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    state_q == sdfm_pkg::SDFM_IDLE && pin_q[2]
    |=> code_q == `SDFM_CODE_CUR_SENSOR)
    else $error("sensor fault not code 104");
  a_type_flag: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    det[12] |=> flags_q[12])
    else $error("encoder type flag missing");
  a_clear_idle: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    state_q == sdfm_pkg::SDFM_LATCHED && i_fault_clear && !any_det
    |=> state_q == sdfm_pkg::SDFM_IDLE ##1 !o_fault_active)
    else $error("clear did not release fault");
  a_jump_code: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    s_detect_jump |=> code_q == `SDFM_CODE_JUMP ##1 o_fault_code == `SDFM_CODE_JUMP)
    else $error("jump fault not reported as 109");
  a_nvm_flag: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    i_nvm_read_err |=> flags_q[2])
    else $error("memory read flag missing");
  a_regpath_flag: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    i_reg_wr_valid && (i_reg_wr_value != i_reg_rd_value) |=> flags_q[4])
    else $error("register path flag missing");
  a_index_flag: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    i_enc_learn_done && !i_index_seen |=> flags_q[7])
    else $error("missing index flag not raised");
  a_winding_flag: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    i_wind_learn && i_wind_wrong_dir |=> flags_q[6])
    else $error("winding flag not raised");
endmodule
`default_nettype wire

/* File: sdfm_motor_model.sv */
`timescale 1ns/1ps
`default_nettype none
`include "sdfm_defines.svh"
// motor side: rotating hall code, sensor fault pins, periodic current samples
module sdfm_motor_model (
  input wire logic i_mclk,
  input wire logic [2:0] i_fail,
  input wire logic [1:0] i_hall_stuck,
  input wire logic [`SDFM_CUR_W-1:0] i_amp,
  output logic o_cur_sensor_fail,
  output logic o_enc_signal_bad,
  output logic o_phase_diff_big,
  output logic [2:0] o_hall,
  output logic o_cur_valid,
  output logic [`SDFM_CUR_W-1:0] o_cur_sample
);
  logic [2:0] step_q = 3'h0;
  logic [1:0] cnt_q = 2'h0;
  logic [2:0] seq [0:5] = '{3'h1, 3'h3, 3'h2, 3'h6, 3'h4, 3'h5};
  assign o_cur_sensor_fail = i_fail[0];
  assign o_enc_signal_bad = i_fail[1];
  assign o_phase_diff_big = i_fail[2];
  assign o_cur_valid = (cnt_q == 2'h3);
  // sample lines carry junk between valid strobes
  assign o_cur_sample = o_cur_valid ? i_amp : ~i_amp;
  assign o_hall = (i_hall_stuck == 2'h1) ? 3'h0 : (i_hall_stuck == 2'h2) ? 3'h7 : seq[step_q];
  always @(posedge i_mclk) begin
    step_q <= (step_q == 3'h5) ? 3'h0 : step_q + 3'h1;
    cnt_q <= cnt_q + 2'h1;
  end
endmodule
`default_nettype wire

/* File: servo_drive_fault_monitor_bench.sv */
`timescale 1ns/1ps
`default_nettype none
`include "sdfm_defines.svh"
module servo_drive_fault_monitor_bench;
  logic i_mclk = 1'b0;
  logic i_rst_n = 1'b0;
  logic nvm, wrv, wind, wdir, ldone, seen, elearn, pwr, rwire, clr, cfail, ebad, pbig, cval, act;
  logic [2:0] fail, hall;
  logic [1:0] stuck;
  logic [31:0] wval, rval;
  logic [15:0] amp, csamp, temp, thr, dtype, ctype, mask;
  logic [23:0] pos, res;
  logic [7:0] code;
  logic [12:0] flags;
  logic [31:0] lfsr = 32'h835E;
  int fail_count = 0;
  int n_checks = 0;
  always #2 i_mclk = ~i_mclk;
  sdfm_motor_model sdfm_motor_model_inst (.i_mclk(i_mclk), .i_fail(fail), .i_hall_stuck(stuck),
    .i_amp(amp), .o_cur_sensor_fail(cfail), .o_enc_signal_bad(ebad), .o_phase_diff_big(pbig),
    .o_hall(hall), .o_cur_valid(cval), .o_cur_sample(csamp));
  sdfm_top sdfm_top_inst (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_cur_sensor_fail(cfail),
    .i_enc_signal_bad(ebad), .i_nvm_read_err(nvm), .i_phase_diff_big(pbig), .i_reg_wr_valid(wrv),
    .i_reg_wr_value(wval), .i_reg_rd_value(rval), .i_cur_valid(cval), .i_cur_sample(csamp),
    .i_wind_learn(wind), .i_wind_wrong_dir(wdir), .i_enc_learn_done(ldone), .i_index_seen(seen),
    .i_index_pos(pos), .i_enc_resolution(res), .i_enc_learn(elearn), .i_hall(hall),
    .i_drive_temperature_reading(temp), .i_overheat_threshold(thr), .i_pwron_check(pwr),
    .i_reduced_wire_enc(rwire), .i_detected_encoder_type(dtype[3:0]),
    .i_configured_encoder_type(ctype[3:0]), .i_fault_mask_parameter(mask),
    .i_fault_clear(clr), .o_fault_active(act), .o_fault_code(code), .o_fault_flags(flags));
  function automatic logic [31:0] next_rand(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [7:0] exp_code(input int idx);
    logic [7:0] t [0:12] = '{8'h68, 8'h69, 8'h6A, 8'h6B, 8'h6C, 8'h6D, 8'h6F, 8'h71, 8'h72,
      8'h73, 8'h75, 8'h76, 8'h77};
    return t[idx];
  endfunction
  task chk(input string name, input logic [31:0] seen_v, input logic [31:0] exp_v);
    n_checks++;
    if (seen_v !== exp_v) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", name, exp_v, seen_v);
    end
  endtask
  task end_of_test;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // benign values: equal temperature and index position sit on the limits
  task idle;
    {fail, stuck, nvm, wrv, wind, ldone, elearn, pwr, clr} = '0;
    {wdir, seen, rwire} = 3'h7;
    {wval, rval} = {lfsr, lfsr};
    amp = 16'h03E8;
    thr = lfsr[15:0] >> 1;
    temp = thr;
    res = lfsr[23:0] >> 1;
    pos = res;
    dtype = {12'h000, lfsr[3:0]};
    ctype = dtype;
  endtask
  task apply(input int idx);
    case (idx)
      0: fail[0] = 1'b1;
      1: fail[1] = 1'b1;
      2: nvm = 1'b1;
      3: fail[2] = 1'b1;
      4: {wrv, rval} = {1'b1, ~wval};
      5: amp = 16'h0BB8;
      6: wind = 1'b1;
      7: {ldone, seen} = 2'h2;
      8: {ldone, pos} = {1'b1, res + 24'h000001};
      9: {elearn, stuck} = 3'h5;
      10: temp = thr + 16'h0001;
      11: {pwr, stuck} = 3'h6;
      default: ctype = {12'h000, dtype[3:0] + 4'h1};
    endcase
  endtask
  task hit(input int idx);
    @(negedge i_mclk);
    apply(idx);
    repeat (8) @(negedge i_mclk);
    idle();
    repeat (10) @(negedge i_mclk);
  endtask
  task clear;
    clr = 1'b1;
    @(negedge i_mclk);
    clr = 1'b0;
    repeat (4) @(negedge i_mclk);
  endtask
  initial begin
    mask = 16'h0000;
    idle();
    repeat (16) @(negedge i_mclk);
    chk("reset code", {act, code}, 9'h000);
    i_rst_n = 1'b1;
    for (int k = 0; k < 26; k++) begin
      lfsr = next_rand(lfsr);
      idle();
      repeat (10) @(negedge i_mclk);
      chk("quiet code", code, 8'h00);
      hit(k % 13);
      chk("code", code, exp_code(k % 13));
      chk("flags", flags, 13'h0001 << (k % 13));
      chk("active", act, 1'b1);
      clear();
      chk("cleared", {act, code, flags}, 22'h000000);
    end
    mask = 16'h0004;
    hit(3);
    chk("masked phase", {code, flags}, 21'h000000);
    mask = 16'h0008;
    hit(5);
    chk("masked jump", {code, flags}, 21'h000000);
    mask = 16'h0000;
    {wind, wdir, pwr, rwire, stuck} = {4'hA, 2'h1};
    repeat (8) @(negedge i_mclk);
    chk("gated faults", {act, code, flags}, 22'h000000);
    idle();
    temp = thr + 16'h0001;
    repeat (6) @(negedge i_mclk);
    fail[0] = 1'b1;
    repeat (8) @(negedge i_mclk);
    chk("held code", code, 8'h75);
    chk("held flags", flags, 13'h0401);
    temp = thr;
    clear();
    chk("relatch", code, 8'h68);
    i_rst_n = 1'b0;
    idle();
    pwr = 1'b1;
    repeat (2) @(negedge i_mclk);
    chk("reset again", {act, code, flags}, 22'h000000);
    i_rst_n = 1'b1;
    repeat (8) @(negedge i_mclk);
    chk("power-on hall", {act, code, flags}, 22'h000000);
    end_of_test();
  end
  initial begin
    repeat (3000) @(posedge i_mclk);
    fail_count++;
    end_of_test();
  end
endmodule
`default_nettype wire
